// >>> gtc_cfg.svh
// Register offsets, field positions, reset values and limits of the timer.
`ifndef GTC_CFG_SVH
`define GTC_CFG_SVH
`define GTC_OFF_CTRL    8'h00
`define GTC_OFF_CMD     8'h04
`define GTC_OFF_PERIOD  8'h08
`define GTC_OFF_DUTY    8'h0C
`define GTC_OFF_COUNT   8'h10
`define GTC_OFF_STATUS  8'h14
`define GTC_OFF_CLKHZ   8'h18
`define GTC_OFF_CAPA    8'h1C
`define GTC_OFF_CAPB    8'h20
`define GTC_OFF_IRQST   8'h24
`define GTC_OFF_IRQMSK  8'h28
`define GTC_CTRL_MODE   0
`define GTC_CTRL_DIR    2
`define GTC_CTRL_SEL    3
`define GTC_CTRL_CAPEN  7
`define GTC_CTRL_PIN    8
`define GTC_CMD_START   0
`define GTC_CMD_STOP    1
`define GTC_CMD_RESET   2
`define GTC_EV_CYCLE    0
`define GTC_EV_CAPA     1
`define GTC_EV_CAPB     2
`define GTC_RST_SEL     4'h0
`define GTC_RST_MASK    3'h0
`define GTC_SEL_MAX     4'h9
`define GTC_PRE_W       10
`endif

// >>> gtc_core.sv
// General timer core: prescaled up/down counter with APB registers.
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "gtc_cfg.svh"
module gtc_core
    import gtc_pkg::*;
#(
    parameter int W      = 32,          // Counter width, 16 or 32.
    parameter int AW     = 8,           // APB address width.
    parameter int SRC_HZ = 50000000     // Source clock rate in Hz.
) (
    input  wire logic          I_CLK,     // Source clock.
    input  wire logic          I_NRST,    // Async reset, active low.
    input  wire logic          I_PSEL,    // APB select.
    input  wire logic          I_PENABLE, // APB access phase.
    input  wire logic          I_PWRITE,  // APB direction, 1 = write.
    input  wire logic [AW-1:0] I_PADDR,   // APB byte address.
    input  wire logic [31:0]   I_PWDATA,  // APB write data.
    input  wire logic          I_CAP_A,   // Capture input A.
    input  wire logic          I_CAP_B,   // Capture input B.
    output logic               O_PREADY,  // APB ready.
    output logic               O_PSLVERR, // APB error, unmapped address.
    output logic [31:0]        O_PRDATA,  // APB read data.
    output logic               O_IRQ,     // Level interrupt.
    output logic [1:0]         O_PWM      // PWM pins, one selected.
);
    localparam int PW = `GTC_PRE_W;

    // The whole state of the block in one record.
    typedef struct packed {
        gtc_run_t        run;      // Run state.
        gtc_mode_t       mode;     // Operating mode.
        gtc_dir_t        dir;      // Count direction.
        logic [3:0]      sel;      // Prescaler code.
        logic            cap_en;   // Capture enable.
        logic            pin;      // PWM pin select.
        logic [W-1:0]    period;   // Period in ticks.
        logic [W-1:0]    duty;     // Duty as written.
        logic [W-1:0]    duty_act; // Duty in use this cycle.
        logic [W-1:0]    cnt;      // Live counter.
        logic [W-1:0]    cap_a;    // Capture A value.
        logic [W-1:0]    cap_b;    // Capture B value.
        logic [PW-1:0]   presc;    // Prescaler count.
        logic [2:0]      stat;     // Sticky event bits.
        logic [2:0]      mask;     // Interrupt enables.
        logic            prev_a;   // Capture A last level.
        logic            prev_b;   // Capture B last level.
        logic            pready;   // APB ready flop.
        logic            pslverr;  // APB error flop.
        logic [31:0]     prdata;   // APB read data flop.
        logic            irq;      // Interrupt flop.
        logic [1:0]      pwm;      // PWM pin flops.
    } gtc_state_t;

    gtc_state_t r;       // Registered state.
    gtc_state_t next_r;  // Next state.

    // Terminal prescaler count for a code; 512 does not exist.
    function automatic logic [PW-1:0] div_tc(input logic [3:0] s);
        logic [PW-1:0] v;
        v = '0;
        if (s >= `GTC_SEL_MAX) begin
            v = '1;
        end else begin
            v = PW'((1 << s) - 1);
        end
        return v;
    endfunction

    // Counting clock rate in Hz for a code.
    function automatic logic [31:0] tick_hz(input logic [3:0] s);
        logic [31:0] h;
        h = 32'(SRC_HZ);
        if (s >= `GTC_SEL_MAX) begin
            h = h >> PW;
        end else begin
            h = h >> s;
        end
        return h;
    endfunction

    // Zero-extends a counter-wide value to the bus width.
    function automatic logic [31:0] ext(input logic [W-1:0] v);
        logic [31:0] e;
        e = '0;
        e[W-1:0] = v;
        return e;
    endfunction

    logic          running;  // Counter is counting.
    logic          tick;     // Prescaled tick this cycle.
    logic [W-1:0]  top;      // Last value of an up cycle, first of a down one.
    logic [W-1:0]  init;     // Start value of a cycle.
    logic          expire;   // Cycle ends at this edge.
    logic          rise_a;   // Rising edge on capture A.
    logic          rise_b;   // Rising edge on capture B.
    logic          acc;      // First access cycle, data prepared.
    logic          done;     // Completion edge of a transfer.
    logic [W-1:0]  elapsed;  // Ticks into the next cycle state.
    logic          pwm_on;   // PWM level for the next cycle.

    // Shared decode of the counter and bus conditions.
    always_comb begin
        running = (r.run == GTC_COUNTING);
        tick = running && (r.presc == div_tc(r.sel));
        // Free running uses the whole range; else period ticks.
        top = (r.mode == GTC_FREE) ? '1 : W'(r.period - 1'b1);
        init = (r.dir == GTC_UP) ? '0 : top;
        if (r.dir == GTC_UP) begin
            // Compare with >= so a shortened period cannot run away.
            expire = tick && (r.cnt >= top);
        end else begin
            expire = tick && (r.cnt == '0);
        end
        // Last levels reset low like idle pins: no false edge.
        rise_a = I_CAP_A && !r.prev_a;
        rise_b = I_CAP_B && !r.prev_b;
        // One wait state: data is prepared here, pready rises next.
        acc = I_PSEL && I_PENABLE && !r.pready;
        done = I_PSEL && I_PENABLE && r.pready;
    end

    // Next-state logic: counter, commands, capture, bus and interrupt.
    always_comb begin
        next_r = r;
        next_r.prev_a = I_CAP_A;
        next_r.prev_b = I_CAP_B;
        // Prescaler restarts with each tick and rests while stopped.
        if (!running || tick) begin
            next_r.presc = '0;
        end else begin
            next_r.presc = PW'(r.presc + 1'b1);
        end
        // Counter steps one per tick, reloading at cycle end.
        if (expire) begin
            next_r.cnt = init;
            next_r.duty_act = r.duty;
            if (r.mode == GTC_ONESHOT) begin
                next_r.run = GTC_STOPPED;
            end
        end else if (tick) begin
            if (r.dir == GTC_UP) begin
                next_r.cnt = W'(r.cnt + 1'b1);
            end else begin
                next_r.cnt = W'(r.cnt - 1'b1);
            end
        end
        // With the counter idle the buffered duty applies at once.
        if (!running) begin
            next_r.duty_act = r.duty;
        end
        // Captures, only while enabled.
        if (r.cap_en && rise_a) begin
            next_r.cap_a = r.cnt;
        end
        if (r.cap_en && rise_b) begin
            next_r.cap_b = r.cnt;
        end
        // Bus: data prepared in the first access cycle.
        next_r.pready = acc;
        if (acc) begin
            next_r.pslverr = 1'b0;
            next_r.prdata = '0;
            unique case (I_PADDR)
                `GTC_OFF_CTRL: begin
                    next_r.prdata[`GTC_CTRL_MODE +: 2] = r.mode;
                    next_r.prdata[`GTC_CTRL_DIR] = r.dir;
                    next_r.prdata[`GTC_CTRL_SEL +: 4] = r.sel;
                    next_r.prdata[`GTC_CTRL_CAPEN] = r.cap_en;
                    next_r.prdata[`GTC_CTRL_PIN] = r.pin;
                end
                `GTC_OFF_CMD: begin
                    next_r.prdata = '0; // Write-only commands.
                end
                `GTC_OFF_PERIOD: begin
                    next_r.prdata = ext(r.period);
                end
                `GTC_OFF_DUTY: begin
                    next_r.prdata = ext(r.duty);
                end
                `GTC_OFF_COUNT: begin
                    next_r.prdata = ext(r.cnt);
                end
                `GTC_OFF_STATUS: begin
                    next_r.prdata[0] = r.run;
                    next_r.prdata[1] = r.dir;
                end
                `GTC_OFF_CLKHZ: begin
                    next_r.prdata = tick_hz(r.sel);
                end
                `GTC_OFF_CAPA: begin
                    next_r.prdata = ext(r.cap_a);
                end
                `GTC_OFF_CAPB: begin
                    next_r.prdata = ext(r.cap_b);
                end
                `GTC_OFF_IRQST: begin
                    next_r.prdata[2:0] = r.stat;
                end
                `GTC_OFF_IRQMSK: begin
                    next_r.prdata[2:0] = r.mask;
                end
                default: begin
                    next_r.pslverr = 1'b1; // Unmapped address.
                end
            endcase
        end
        // Writes and read side effects act at the completion edge.
        if (done && I_PWRITE && !r.pslverr) begin
            unique case (I_PADDR)
                `GTC_OFF_CTRL: begin
                    next_r.mode = gtc_mode_t'(
                        I_PWDATA[`GTC_CTRL_MODE +: 2]);
                    next_r.dir = gtc_dir_t'(I_PWDATA[`GTC_CTRL_DIR]);
                    // Codes above the 1024 setting are ignored.
                    if (I_PWDATA[`GTC_CTRL_SEL +: 4] <= `GTC_SEL_MAX) begin
                        next_r.sel = I_PWDATA[`GTC_CTRL_SEL +: 4];
                    end
                    next_r.cap_en = I_PWDATA[`GTC_CTRL_CAPEN];
                    next_r.pin = I_PWDATA[`GTC_CTRL_PIN];
                end
                `GTC_OFF_CMD: begin
                    // Reset reloads only counter and prescaler.
                    if (I_PWDATA[`GTC_CMD_RESET]) begin
                        next_r.cnt = init;
                        next_r.presc = '0;
                    end
                    if (I_PWDATA[`GTC_CMD_START] && !running) begin
                        next_r.run = GTC_COUNTING;
                        next_r.presc = '0;
                    end
                    // Stop wins when start and stop come together.
                    if (I_PWDATA[`GTC_CMD_STOP]) begin
                        next_r.run = GTC_STOPPED;
                    end
                end
                `GTC_OFF_PERIOD: begin
                    // Applies at once; a down count uses it at reload.
                    next_r.period = I_PWDATA[W-1:0];
                end
                `GTC_OFF_DUTY: begin
                    next_r.duty = I_PWDATA[W-1:0];
                end
                `GTC_OFF_IRQMSK: begin
                    next_r.mask = I_PWDATA[2:0];
                end
                default: begin
                    next_r.mask = r.mask; // Read-only, ignored.
                end
            endcase
        end
        // Events set sticky bits; a set wins over the read clear.
        next_r.stat = r.stat;
        if (done && !I_PWRITE && (I_PADDR == `GTC_OFF_IRQST)) begin
            next_r.stat = r.stat & ~r.prdata[2:0];
        end
        next_r.stat[`GTC_EV_CYCLE] = next_r.stat[`GTC_EV_CYCLE]
            | expire;
        next_r.stat[`GTC_EV_CAPA] = next_r.stat[`GTC_EV_CAPA]
            | (r.cap_en && rise_a);
        next_r.stat[`GTC_EV_CAPB] = next_r.stat[`GTC_EV_CAPB]
            | (r.cap_en && rise_b);
        // Built from next values so the line tracks the status flops.
        next_r.irq = |(next_r.stat & next_r.mask);
        // PWM level follows the next counter position; a down count
        // measures its ticks back from the top of the cycle.
        if (next_r.dir == GTC_UP) begin
            elapsed = next_r.cnt;
        end else begin
            elapsed = W'(top - next_r.cnt);
        end
        pwm_on = (next_r.run == GTC_COUNTING)
            && (next_r.mode == GTC_PWM)
            && (elapsed < next_r.duty_act);
        next_r.pwm = next_r.pin ? {pwm_on, 1'b0} : {1'b0, pwm_on};
    end

    // State register; reset leaves the timer stopped, full range.
    // All ones for the period gives the widest range until it is set.
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            r <= '0;
            r.run <= GTC_STOPPED;
            r.mode <= GTC_PERIODIC;
            r.dir <= GTC_UP;
            r.sel <= `GTC_RST_SEL;
            r.mask <= `GTC_RST_MASK;
            r.period <= '1;
        end else begin
            r <= next_r;
        end
    end

    assign O_PREADY = r.pready;
    assign O_PSLVERR = r.pslverr;
    assign O_PRDATA = r.prdata;
    assign O_IRQ = r.irq;
    assign O_PWM = r.pwm;

    // Checks on the block's own behaviour. They watch the registered
    // state, so a failure points at the flop that went wrong.
    default clocking dcb @(posedge I_CLK);
    endclocking
    default disable iff (!I_NRST);

    chk_oneshot_stop: assert property (
        expire && r.mode == GTC_ONESHOT |=> r.run == GTC_STOPPED)
        else $error("One-shot did not stop at expiry.");
    chk_periodic_go: assert property (
        expire && r.mode == GTC_PERIODIC && !done
        |=> r.run == GTC_COUNTING && r.cnt == $past(init))
        else $error("Periodic cycle did not restart.");
    chk_cycle_flag: assert property (
        expire |=> r.stat[`GTC_EV_CYCLE] ##1 O_IRQ || !r.mask[0])
        else $error("Cycle end not flagged.");
    chk_irq_gate: assert property (
        O_IRQ == (|(r.stat & r.mask)))
        else $error("Interrupt line disagrees with masked status.");
    chk_cap_latch: assert property (
        r.cap_en && rise_a |=> r.cap_a == $past(r.cnt)
        && r.stat[`GTC_EV_CAPA])
        else $error("Capture A did not latch.");
    chk_cap_off: assert property (
        !r.cap_en && $stable(r.cap_en) |=> $stable(r.cap_b))
        else $error("Capture B changed while disabled.");
    chk_duty_hold: assert property (
        running && !expire |=> r.duty_act == $past(r.duty_act))
        else $error("Duty changed in mid-cycle.");
    chk_stop_hold: assert property (
        !running && !done |=> $stable(r.cnt))
        else $error("Counter moved while stopped.");
    chk_div_two: assert property (
        tick && r.sel == 4'h1 && $stable(r.sel) && !done |=> !tick)
        else $error("Divide by two ticked twice in a row.");
    chk_up_step: assert property (
        tick && !expire && r.dir == GTC_UP && !done
        |=> r.cnt == W'($past(r.cnt) + 1'b1))
        else $error("Up count did not step by one.");
    chk_pwm_idle: assert property (
        r.mode != GTC_PWM |-> O_PWM == 2'h0)
        else $error("PWM pin driven outside PWM mode.");
    chk_reset_keep: assert property (
        done && I_PWRITE && I_PADDR == `GTC_OFF_CMD
        |=> $stable(r.period) && $stable(r.duty) && $stable(r.mode))
        else $error("Command changed configuration.");
    // Capture B and the one-shot reload mirror their siblings above.
    chk_capb_latch: assert property (
        r.cap_en && rise_b |=> r.cap_b == $past(r.cnt)
        && r.stat[`GTC_EV_CAPB])
        else $error("Capture B did not latch.");
    chk_oneshot_init: assert property (
        expire && r.mode == GTC_ONESHOT && !done
        |=> r.cnt == $past(init))
        else $error("One-shot did not return to its start value.");
endmodule
`default_nettype wire

// >>> gtc_pkg.sv
// Types shared by the general timer core.
package gtc_pkg;
    // Operating behaviour of the counter.
    typedef enum logic [1:0] {
        GTC_PERIODIC = 2'h0,
        GTC_ONESHOT  = 2'h1,
        GTC_PWM      = 2'h3,
        GTC_FREE     = 2'h2
    } gtc_mode_t;
    // Count direction.
    typedef enum logic {
        GTC_DOWN = 1'h0,
        GTC_UP   = 1'h1
    } gtc_dir_t;
    // Run state, stopped or counting.
    typedef enum logic {
        GTC_STOPPED  = 1'h0,
        GTC_COUNTING = 1'h1
    } gtc_run_t;
endpackage

// >>> tb_gtc_core.sv
// Self-checking testbench for the general timer core, driven over APB.
`timescale 1ns/1ns
`default_nettype none
`include "gtc_cfg.svh"
module tb_top
    import gtc_pkg::*;
;
    logic        clk;        // Source clock, 50 MHz.
    logic        nrst;       // Reset, active low.
    logic        psel;       // APB select.
    logic        penable;    // APB access phase.
    logic        pwrite;     // APB direction.
    logic [7:0]  paddr;      // APB byte address.
    logic [31:0] pwdata;     // APB write data.
    logic        cap_a;      // Capture input A.
    logic        cap_b;      // Capture input B.
    logic        pready;     // APB ready from the timer.
    logic        pslverr;    // APB error from the timer.
    logic [31:0] prdata;     // APB read data from the timer.
    logic        irq;        // Level interrupt.
    logic [1:0]  pwm;        // PWM pins.
    logic [31:0] rd;         // Data taken at the last completion edge.
    logic        er;         // Error flag taken with it.
    int          fail_count; // Mismatches seen.
    int          n_tests;    // Comparisons made.
    int          hi;         // Cycles counted by the wait and PWM tasks.

    // Free-running clock, 20 ns period.
    initial clk = 1'b0;
    always #10 clk = ~clk;

    gtc_core #(.W(32), .AW(8), .SRC_HZ(50000000)) DUT (
        .I_CLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .I_CAP_A(cap_a), .I_CAP_B(cap_b), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .O_PRDATA(prdata), .O_IRQ(irq), .O_PWM(pwm));

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Compares a seen value with the expected one and counts both.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        // A slave that never answers ends the run here.
        if (n == 16) begin
            fail_count++;
            final_report();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Shorthands for a register write and a checked register read.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    // Builds a control word from its fields.
    function automatic logic [31:0] ctrl(input logic [1:0] m,
        input logic dir, input logic [3:0] sel, input logic cen,
        input logic pin);
        return {23'h0, pin, cen, sel, dir, m};
    endfunction

    // Counts cycles until a PWM bit (0, 1) or the interrupt (2) reaches lvl.
    task automatic wait_lvl(input int s, input logic lvl, input int lim);
        logic v;
        hi = 0;
        do begin
            @(posedge clk);
            hi++;
            v = (s == 2) ? irq : pwm[s];
        end while (v !== lvl && hi < lim);
        // A level that never comes is a failure, not a hang.
        if (v !== lvl) begin
            fail_count++;
            final_report();
        end
    endtask

    // Counts the high cycles of one PWM bit over a window.
    task automatic pwm_hi(input int cyc, input int b);
        hi = 0;
        repeat (cyc) begin
            @(posedge clk);
            if (pwm[b] === 1'b1) hi++;
        end
    endtask

    // One-cycle pulses on the capture inputs.
    task automatic pulse(input logic a, input logic b);
        @(posedge clk);
        cap_a <= a;
        cap_b <= b;
        @(posedge clk);
        cap_a <= 1'b0;
        cap_b <= 1'b0;
    endtask

    // Main sequence: reset, register map, modes, interrupts, captures.
    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cap_a = 1'b0;
        cap_b = 1'b0;
        fail_count = 0;
        n_tests = 0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rdchk(`GTC_OFF_CTRL, 32'h4);
        rdchk(`GTC_OFF_PERIOD, 32'hFFFFFFFF);
        rdchk(`GTC_OFF_STATUS, 32'h2);
        rdchk(`GTC_OFF_IRQMSK, 32'h0);
        apb(1'b0, 8'h2C, 32'h0);
        check({31'h0, er}, 32'h1);
        wr(`GTC_OFF_COUNT, 32'h55);
        check({31'h0, er}, 32'h0);
        rdchk(`GTC_OFF_COUNT, 32'h0);
        for (int m = 0; m < 4; m++) begin
            wr(`GTC_OFF_CTRL, ctrl(m[1:0], 1'b1, 4'h0, 1'b0, 1'b0));
            rdchk(`GTC_OFF_CTRL, ctrl(m[1:0], 1'b1, 4'h0, 1'b0, 1'b0));
        end
        for (int c = 0; c < 10; c++) begin
            wr(`GTC_OFF_CTRL, ctrl(2'h0, 1'b1, c[3:0], 1'b0, 1'b0));
            rdchk(`GTC_OFF_CLKHZ, 50000000 >> ((c == 9) ? 10 : c));
        end
        // Code ten has no divider behind it, so the field keeps nine.
        wr(`GTC_OFF_CTRL, ctrl(2'h0, 1'b1, 4'hA, 1'b0, 1'b0));
        rdchk(`GTC_OFF_CTRL, ctrl(2'h0, 1'b1, 4'h9, 1'b0, 1'b0));
        // Periodic up count with the cycle-end interrupt unmasked.
        wr(`GTC_OFF_CTRL, ctrl(GTC_PERIODIC, GTC_UP, 4'h0, 1'b0, 1'b0));
        wr(`GTC_OFF_PERIOD, 32'h5);
        wr(`GTC_OFF_IRQMSK, 32'h1);
        wr(`GTC_OFF_CMD, 32'h1);
        wait_lvl(2, 1'b1, 20);
        check({31'h0, irq}, 32'h1);
        repeat (30) @(posedge clk);
        rdchk(`GTC_OFF_STATUS, 32'h3);
        apb(1'b0, `GTC_OFF_COUNT, 32'h0);
        check({31'h0, rd < 32'h5}, 32'h1);
        wr(`GTC_OFF_CMD, 32'h2);
        rdchk(`GTC_OFF_STATUS, 32'h2);
        rdchk(`GTC_OFF_IRQST, 32'h1);
        rdchk(`GTC_OFF_IRQST, 32'h0);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        // Masked expiry still flags the event but keeps the line low.
        wr(`GTC_OFF_IRQMSK, 32'h0);
        wr(`GTC_OFF_CMD, 32'h1);
        repeat (20) @(posedge clk);
        wr(`GTC_OFF_CMD, 32'h2);
        check({31'h0, irq}, 32'h0);
        rdchk(`GTC_OFF_IRQST, 32'h1);
        // One-shot stops by itself at the initial value.
        wr(`GTC_OFF_CMD, 32'h4);
        wr(`GTC_OFF_CTRL, ctrl(GTC_ONESHOT, GTC_UP, 4'h0, 1'b0, 1'b0));
        wr(`GTC_OFF_PERIOD, 32'h4);
        wr(`GTC_OFF_CMD, 32'h1);
        repeat (12) @(posedge clk);
        rdchk(`GTC_OFF_STATUS, 32'h2);
        rdchk(`GTC_OFF_COUNT, 32'h0);
        rdchk(`GTC_OFF_IRQST, 32'h1);
        // Free running ignores the period and counts on past it.
        wr(`GTC_OFF_CTRL, ctrl(GTC_FREE, GTC_UP, 4'h0, 1'b0, 1'b0));
        wr(`GTC_OFF_CMD, 32'h1);
        repeat (20) @(posedge clk);
        apb(1'b0, `GTC_OFF_COUNT, 32'h0);
        check({31'h0, rd > 32'h4}, 32'h1);
        wr(`GTC_OFF_CMD, 32'h6);
        rdchk(`GTC_OFF_IRQST, 32'h0);
        // PWM on pin 1: three of every eight cycles high, pin 0 idle.
        wr(`GTC_OFF_PERIOD, 32'h8);
        wr(`GTC_OFF_DUTY, 32'h3);
        wr(`GTC_OFF_CTRL, ctrl(GTC_PWM, GTC_UP, 4'h0, 1'b0, 1'b1));
        wr(`GTC_OFF_CMD, 32'h1);
        repeat (16) @(posedge clk);
        pwm_hi(40, 1);
        check(hi, 32'd15);
        pwm_hi(40, 0);
        check(hi, 32'd0);
        // A long period exposes a duty change applied in mid-cycle.
        wr(`GTC_OFF_PERIOD, 32'd200);
        wr(`GTC_OFF_DUTY, 32'd10);
        wait_lvl(1, 1'b1, 400);
        wait_lvl(1, 1'b0, 400);
        check(hi, 32'd10);
        wr(`GTC_OFF_DUTY, 32'd100);
        wait_lvl(1, 1'b1, 400);
        check({31'h0, hi > 150}, 32'h1);
        wait_lvl(1, 1'b0, 400);
        check(hi, 32'd100);
        // Divide by four: one tick high in four, sixteen cycles a period.
        wr(`GTC_OFF_CMD, 32'h2);
        wr(`GTC_OFF_CTRL, ctrl(GTC_PWM, GTC_UP, 4'h2, 1'b0, 1'b1));
        wr(`GTC_OFF_PERIOD, 32'h4);
        wr(`GTC_OFF_DUTY, 32'h1);
        wr(`GTC_OFF_CMD, 32'h5);
        repeat (32) @(posedge clk);
        pwm_hi(64, 1);
        check(hi, 32'd16);
        // Down count reset, then captures gated and ungated.
        wr(`GTC_OFF_CMD, 32'h2);
        wr(`GTC_OFF_CTRL, ctrl(GTC_PERIODIC, GTC_DOWN, 4'h0, 1'b0, 1'b0));
        wr(`GTC_OFF_PERIOD, 32'h7);
        wr(`GTC_OFF_CMD, 32'h4);
        rdchk(`GTC_OFF_COUNT, 32'h6);
        rdchk(`GTC_OFF_PERIOD, 32'h7);
        rdchk(`GTC_OFF_STATUS, 32'h0);
        apb(1'b0, `GTC_OFF_IRQST, 32'h0);
        pulse(1'b1, 1'b1);
        rdchk(`GTC_OFF_IRQST, 32'h0);
        rdchk(`GTC_OFF_CAPA, 32'h0);
        wr(`GTC_OFF_CTRL, ctrl(GTC_PERIODIC, GTC_DOWN, 4'h0, 1'b1, 1'b0));
        pulse(1'b0, 1'b1);
        rdchk(`GTC_OFF_IRQST, 32'h4);
        rdchk(`GTC_OFF_CAPB, 32'h6);
        wr(`GTC_OFF_IRQMSK, 32'h2);
        pulse(1'b1, 1'b0);
        rdchk(`GTC_OFF_CAPA, 32'h6);
        check({31'h0, irq}, 32'h1);
        rdchk(`GTC_OFF_IRQST, 32'h2);
        final_report();
    end
endmodule
`default_nettype wire
